// [design/eeprom_prot_pkg.sv]
// constants, opcodes and state layout of the serial eeprom protection block
// assumes a 100 MHz system clock and a slow serial link sampled by it
package eeprom_prot_pkg;
   localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
   localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam int HW_EN_BIT    = 7;
   localparam int GUARD_HI_BIT = 3;
   localparam int GUARD_LO_BIT = 2;
   localparam int LATCH_BIT    = 1;
   localparam int BUSY_BIT     = 0;
   localparam logic [4:0] OPCODE_BITS = 5'h08;
   localparam logic [4:0] STATUS_WRITE_BITS = 5'h10;
   localparam logic [12:0] QUARTER_BASE = 13'h1800;
   localparam logic [12:0] HALF_BASE    = 13'h1000;
   localparam logic [12:0] ALL_BASE     = 13'h0000;
   localparam logic [2:0] NV_RESET      = 3'h0;
   localparam int CLK_PERIOD_NS = 10;
   localparam int WRITE_TIME_NS = 5000000;
   localparam int WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
   } spi_pins_t;
   typedef struct packed {
      logic [1:0]  cs_sync;
      logic [1:0]  sck_sync;
      logic [1:0]  si_sync;
      logic [1:0]  wp_sync;
      logic        cs_d;
      logic        sck_d;
      logic        armed;
      logic [4:0]  bit_cnt;
      logic [7:0]  shreg;
      logic [7:0]  opcode;
      logic [7:0]  data;
      logic        rd_mode;
      logic [2:0]  out_cnt;
      logic [7:0]  out_sh;
      logic        so;
      logic        so_oe;
      logic        latch;
      logic        hw_en;
      logic        g_hi;
      logic        g_lo;
      logic        busy_t;
      logic [19:0] timer;
      logic        arr_busy;
      logic        grant;
   } prot_state_t;
endpackage

// [design/eeprom_status_write_protect.sv]
// status register and write protection of a serial eeprom
// assumes pins arrive asynchronously; array engine signals share clk
// Function
// - status read is answered at any time, also during a write cycle
// - status word: bit7 hw enable, 3 guard hi, 2 guard lo, 1 latch, 0 busy
// - busy flag is one during an internal write, zero otherwise, read-only
// - latch flag mirrors write latch; one allows writes, zero forbids all
// - latch set and clear commands act even under hardware protection
// - guard bits change only by status write and are nonvolatile
// - guard 00 none, 01 1800h-1FFFh, 10 1000h-1FFFh, 11 whole array
// - status write selects one of four array protection levels
// - hw protect enable is a nonvolatile bit enabling the protect pin
// - hardware protection active only with pin low and enable set
// - hardware protection blocks only status nonvolatile bit writes
// - latch clear protects all; latch set leaves guarded blocks protected
// - write latch is cleared at power-up
// - latch clears when a byte, page or status write completes
// - write cycle starts only when select rises after the exact bit count
// - array accesses during a write cycle are ignored, write completes
// - at power-on standby, select taken high, serial output released
// - after power-on a falling select is needed before activity
// - opcodes 06h set, 04h clear, 05h status read, 01h status write
// - all bytes travel most significant bit first
// - input sampled on rising clock, output changed after falling clock
// - latch set only on select rise right after eight opcode bits
`timescale 1ns/1ps
`default_nettype none
module eeprom_status_write_protect #(
   parameter int WRITE_CYCLES = eeprom_prot_pkg::WRITE_CYCLES
) (
   input  wire logic                       clk,
   input  wire logic                       srst,
   input  wire eeprom_prot_pkg::spi_pins_t pins,
   input  wire logic                       protect_pin_n,
   input  wire logic                       array_write_req,
   input  wire logic [12:0]                array_write_addr,
   input  wire logic                       array_busy,
   input  wire logic                       array_write_done,
   output logic                            so,
   output logic                            so_oe,
   output logic                            array_write_grant,
   output logic                            write_busy_flag,
   output logic                            write_latch_flag
);
   eeprom_prot_pkg::prot_state_t st;
   eeprom_prot_pkg::prot_state_t next_st;

   logic       cs_s;
   logic       sck_s;
   logic       si_s;
   logic       active;
   logic       sck_rise;
   logic       sck_fall;
   logic       cs_rise;
   logic       hw_prot;
   logic       busy;
   logic       guarded;
   logic       commit;
   logic [7:0] status_word;
   logic [7:0] in_byte;

   assign cs_s  = st.cs_sync[1];
   assign sck_s = st.sck_sync[1];
   assign si_s  = st.si_sync[1];
   // idle until a real high select has been seen since reset
   assign active   = st.armed & ~cs_s;
   assign sck_rise = active & sck_s & ~st.sck_d;
   assign sck_fall = active & ~sck_s & st.sck_d;
   assign cs_rise  = st.armed & cs_s & ~st.cs_d;
   assign hw_prot  = st.hw_en & ~st.wp_sync[1];
   assign busy     = st.busy_t | st.arr_busy;
   assign in_byte  = {st.shreg[6:0], si_s};

   always_comb begin
      status_word                               = 8'h00;
      status_word[eeprom_prot_pkg::HW_EN_BIT]    = st.hw_en;
      status_word[eeprom_prot_pkg::GUARD_HI_BIT] = st.g_hi;
      status_word[eeprom_prot_pkg::GUARD_LO_BIT] = st.g_lo;
      status_word[eeprom_prot_pkg::LATCH_BIT]    = st.latch;
      status_word[eeprom_prot_pkg::BUSY_BIT]     = busy;
   end

   always_comb begin
      case ({st.g_hi, st.g_lo})
         2'b01:   guarded = array_write_addr >= eeprom_prot_pkg::QUARTER_BASE;
         2'b10:   guarded = array_write_addr >= eeprom_prot_pkg::HALF_BASE;
         2'b11:   guarded = array_write_addr >= eeprom_prot_pkg::ALL_BASE;
         default: guarded = 1'b0;
      endcase
   end

   // exact 16 bits, latch set, no hardware lock, no write running
   assign commit = cs_rise & (st.bit_cnt == eeprom_prot_pkg::STATUS_WRITE_BITS)
                 & (st.opcode == eeprom_prot_pkg::STATUS_WRITE_CMD)
                 & st.latch & ~hw_prot & ~busy;

   always_comb begin
      next_st          = st;
      next_st.cs_sync  = {st.cs_sync[0], pins.cs_n};
      next_st.sck_sync = {st.sck_sync[0], pins.sck};
      next_st.si_sync  = {st.si_sync[0], pins.si};
      next_st.wp_sync  = {st.wp_sync[0], protect_pin_n};
      next_st.cs_d     = cs_s;
      next_st.sck_d    = sck_s;
      next_st.arr_busy = array_busy;
      if (cs_s) begin
         next_st.armed = 1'b1;
      end
      if (!active) begin
         next_st.bit_cnt = 5'h00;
         next_st.rd_mode = 1'b0;
         next_st.so_oe   = 1'b0;
         next_st.so      = 1'b0;
         next_st.out_cnt = 3'h0;
      end
      if (sck_rise) begin
         next_st.shreg = in_byte;
         if (st.bit_cnt != 5'h1F) begin
            next_st.bit_cnt = st.bit_cnt + 5'h01;
         end
         if (st.bit_cnt == eeprom_prot_pkg::OPCODE_BITS - 5'h01) begin
            next_st.opcode = in_byte;
            if (in_byte == eeprom_prot_pkg::STATUS_READ_CMD) begin
               next_st.rd_mode = 1'b1;
               next_st.out_sh  = status_word;
            end
         end
         if (st.bit_cnt == eeprom_prot_pkg::STATUS_WRITE_BITS - 5'h01) begin
            next_st.data = in_byte;
         end
      end
      if (sck_fall && st.rd_mode) begin
         next_st.so      = st.out_sh[7];
         next_st.so_oe   = 1'b1;
         next_st.out_cnt = st.out_cnt + 3'h1;
         if (st.out_cnt == 3'h7) begin
            next_st.out_sh = status_word;
         end else begin
            next_st.out_sh = {st.out_sh[6:0], 1'b0};
         end
      end
      if (cs_rise && st.bit_cnt == eeprom_prot_pkg::OPCODE_BITS) begin
         if (st.opcode == eeprom_prot_pkg::LATCH_SET_CMD) begin
            next_st.latch = 1'b1;
         end
         if (st.opcode == eeprom_prot_pkg::LATCH_CLEAR_CMD) begin
            next_st.latch = 1'b0;
         end
      end
      if (commit) begin
         next_st.hw_en  = st.data[eeprom_prot_pkg::HW_EN_BIT];
         next_st.g_hi   = st.data[eeprom_prot_pkg::GUARD_HI_BIT];
         next_st.g_lo   = st.data[eeprom_prot_pkg::GUARD_LO_BIT];
         next_st.busy_t = 1'b1;
         next_st.timer  = 20'(WRITE_CYCLES);
      end
      if (st.busy_t) begin
         next_st.timer = st.timer - 20'h00001;
         if (st.timer == 20'h00001) begin
            next_st.busy_t = 1'b0;
            next_st.latch  = 1'b0;
         end
      end
      if (array_write_done) begin
         next_st.latch = 1'b0;
      end
      // busy array ignores the request, the running write goes on
      next_st.grant = array_write_req & st.latch & ~guarded & ~busy;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st         <= '0;
         st.latch   <= 1'b0;
         st.hw_en   <= eeprom_prot_pkg::NV_RESET[2];
         st.g_hi    <= eeprom_prot_pkg::NV_RESET[1];
         st.g_lo    <= eeprom_prot_pkg::NV_RESET[0];
      end else begin
         st <= next_st;
      end
   end

   assign so                = st.so;
   assign so_oe             = st.so_oe;
   assign array_write_grant = st.grant;
   assign write_busy_flag   = st.busy_t;
   assign write_latch_flag  = st.latch;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   property p_latch_set;
      cs_rise && st.bit_cnt == 5'h08 && st.opcode == 8'h06 && !array_write_done
         && !(st.busy_t && st.timer == 20'h00001) |=> st.latch;
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("latch not set");

   property p_latch_clr;
      cs_rise && st.bit_cnt == 5'h08 && st.opcode == 8'h04 |=> !st.latch;
   endproperty
   a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

   property p_no_short_set;
      cs_rise && st.bit_cnt != 5'h08 && !st.latch |=> !st.latch;
   endproperty
   a_no_short_set: assert property (p_no_short_set) else $error("latch set by bad count");

   property p_hw_lock;
      hw_prot && !st.busy_t |=> $stable({st.hw_en, st.g_hi, st.g_lo}) && !st.busy_t;
   endproperty
   a_hw_lock: assert property (p_hw_lock) else $error("status changed while locked");

   sequence s_commit;
      commit ##1 (st.busy_t && st.timer == 20'(WRITE_CYCLES));
   endsequence
   property p_commit;
      commit |-> s_commit;
   endproperty
   a_commit: assert property (p_commit) else $error("status write cycle not started");

   property p_cycle_end;
      st.busy_t && st.timer == 20'h00001 |=> !write_busy_flag && !write_latch_flag;
   endproperty
   a_cycle_end: assert property (p_cycle_end) else $error("latch kept after write");

   property p_grant;
      array_write_grant |-> $past(array_write_req) && $past(st.latch) && !$past(busy);
   endproperty
   a_grant: assert property (p_grant) else $error("grant without permission");

   property p_guard_all;
      st.g_hi && st.g_lo |=> !array_write_grant;
   endproperty
   a_guard_all: assert property (p_guard_all) else $error("write in fully guarded array");

   property p_idle_hiz;
      !st.armed || cs_s |=> !so_oe;
   endproperty
   a_idle_hiz: assert property (p_idle_hiz) else $error("output driven while idle");

   property p_layout;
      status_word[6:4] == 3'h0 && status_word[7] == st.hw_en && status_word[1] == st.latch
         && status_word[3:2] == {st.g_hi, st.g_lo} && status_word[0] == busy;
   endproperty
   a_layout: assert property (p_layout) else $error("status word layout wrong");

   property p_latch_keep;
      !st.latch && !(cs_rise && st.bit_cnt == 5'h08 && st.opcode == 8'h06) |=> !st.latch;
   endproperty
   a_latch_keep: assert property (p_latch_keep) else $error("latch set without command");

   property p_nv_keep;
      !commit |=> $stable({st.hw_en, st.g_hi, st.g_lo});
   endproperty
   a_nv_keep: assert property (p_nv_keep) else $error("guard bits changed outside write");

   property p_unlatched;
      !st.latch |=> !array_write_grant;
   endproperty
   a_unlatched: assert property (p_unlatched) else $error("grant without latch");

   property p_busy_gate;
      busy |=> !array_write_grant;
   endproperty
   a_busy_gate: assert property (p_busy_gate) else $error("grant during write cycle");

   property p_half;
      st.g_hi && !st.g_lo && array_write_addr >= 13'h1000 |=> !array_write_grant;
   endproperty
   a_half: assert property (p_half) else $error("write in guarded upper half");

   property p_quarter;
      !st.g_hi && st.g_lo && array_write_addr >= 13'h1800 |=> !array_write_grant;
   endproperty
   a_quarter: assert property (p_quarter) else $error("write in guarded upper quarter");

   property p_open;
      array_write_req && st.latch && !busy && !st.g_hi && !st.g_lo |=> array_write_grant;
   endproperty
   a_open: assert property (p_open) else $error("permitted write refused");

   property p_pin_high;
      cs_rise && st.bit_cnt == 5'h10 && st.opcode == 8'h01 && st.latch && !busy
         && st.wp_sync[1] |=> st.busy_t;
   endproperty
   a_pin_high: assert property (p_pin_high) else $error("status write refused with pin high");

   property p_busy_run;
      st.busy_t && st.timer != 20'h00001 |=> write_busy_flag;
   endproperty
   a_busy_run: assert property (p_busy_run) else $error("write cycle ended early");

   sequence s_fall_read;
      sck_fall && st.rd_mode;
   endsequence
   sequence s_bit_out;
      so_oe && so == $past(st.out_sh[7]);
   endsequence
   property p_shift;
      s_fall_read |=> s_bit_out;
   endproperty
   a_shift: assert property (p_shift) else $error("status bit not shifted out");

   property p_done;
      array_write_done |=> !write_latch_flag;
   endproperty
   a_done: assert property (p_done) else $error("latch kept after array write");

   property p_unarmed;
      !st.armed |=> st.bit_cnt == 5'h00 && !st.rd_mode;
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("activity before select seen high");
endmodule // eeprom_status_write_protect
`default_nettype wire

// [verif/spi_host_model.sv]
// host side serial master: drives select, clock and data, samples the output
// assumes mode 0 framing, 125 ns link clock that stands low between frames
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   output var eeprom_prot_pkg::spi_pins_t pins,
   input  wire logic                      so
);
   initial pins = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
   // nbits leave msb first from tx[15]; rx keeps the last eight bits read
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [7:0] rx);
      pins.cs_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         pins.si = tx[15 - i];
         #62.5 pins.sck = 1'b1;
         rx = {rx[6:0], so};
         #62.5 pins.sck = 1'b0;
      end
      #62.5 pins.cs_n = 1'b1;
      pins.si = ~pins.si;
      #250;
   endtask
endmodule // spi_host_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench of the status and write protection block
// assumes the serial host model drives the pins; write time shortened
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0, srst = 1'b1, protect_pin_n = 1'b1, array_write_req = 1'b0;
   logic array_busy = 1'b0, array_write_done = 1'b0;
   logic [12:0] array_write_addr = 13'h0000;
   logic so, so_oe, array_write_grant, write_busy_flag, write_latch_flag, so_line;
   eeprom_prot_pkg::spi_pins_t pins;
   int err_total = 0, check_count = 0, cyc = 0, m_hw = 0, m_g = 0, m_lat = 0, m_busy = 0;
   logic [31:0] seed = 32'h0F78;
   logic [7:0] rx, d;
   logic [12:0] addr_list [5] = '{13'h0FFF, 13'h1000, 13'h17FF, 13'h1800, 13'h1FFF};
   always #5 clk = ~clk;
   // a released output shows the inverse, so a read outside the enable fails
   assign so_line = so_oe ? so : ~so;
   spi_host_model spi_host_model_inst (.pins(pins), .so(so_line));
   eeprom_status_write_protect #(.WRITE_CYCLES(400)) eeprom_status_write_protect_inst (
      .clk(clk), .srst(srst), .pins(pins), .protect_pin_n(protect_pin_n),
      .array_write_req(array_write_req), .array_write_addr(array_write_addr),
      .array_busy(array_busy), .array_write_done(array_write_done), .so(so),
      .so_oe(so_oe), .array_write_grant(array_write_grant),
      .write_busy_flag(write_busy_flag), .write_latch_flag(write_latch_flag));
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         err_total++;
         summarize();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic cmd(input logic [7:0] op, input int n);
      spi_host_model_inst.xfer({op, 8'h00}, n, rx);
   endtask
   task automatic status_read();
      spi_host_model_inst.xfer({eeprom_prot_pkg::STATUS_READ_CMD, 8'h00}, 16, rx);
      check(rx & 8'h8F, {m_hw[0], 3'h0, m_g[1:0], m_lat[0], m_busy[0]});
      check({6'h00, so_oe, write_latch_flag}, {7'h00, m_lat[0]});
   endtask
   task automatic status_write(input logic [7:0] v);
      spi_host_model_inst.xfer({eeprom_prot_pkg::STATUS_WRITE_CMD, v}, 16, rx);
      if (m_lat == 1 && !(m_hw == 1 && protect_pin_n == 1'b0)) begin
         {m_hw, m_g, m_busy} = {32'(v[7]), 32'(v[3:2]), 32'd1};
         check({7'h00, write_busy_flag}, {7'h00, m_busy[0]});
         status_read();
         for (int i = 0; i < 2000 && write_busy_flag !== 1'b0; i++) @(negedge clk);
         {m_busy, m_lat} = 64'd0;
      end
      status_read();
   endtask
   task automatic grant(input logic [12:0] a);
      logic e;
      e = m_lat == 1 && array_busy == 1'b0 && !(m_g == 3 || (m_g == 2 && a >= 13'h1000)
          || (m_g == 1 && a >= 13'h1800));
      @(negedge clk) {array_write_addr, array_write_req} = {a, 1'b1};
      repeat (2) @(negedge clk);
      check({7'h00, array_write_grant}, {7'h00, e});
      array_write_req = 1'b0;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      srst = 1'b0;
      check({5'h00, so_oe, write_latch_flag, write_busy_flag}, 8'h00);
      repeat (5) @(negedge clk);
      status_read();
      cmd(eeprom_prot_pkg::LATCH_SET_CMD, 9);
      status_read();
      status_write(8'h8C);
      $display("test power-up and refusals done");
      for (int k = 3; k >= 0; k--) begin
         cmd(eeprom_prot_pkg::LATCH_SET_CMD, 8);
         m_lat = 1;
         d = 8'($random(seed));
         status_write({1'b0, d[6:4], k[1:0], d[1:0]});
         cmd(eeprom_prot_pkg::LATCH_SET_CMD, 8);
         m_lat = 1;
         foreach (addr_list[j]) grant(addr_list[j]);
         d = 8'($random(seed));
         grant({d[4:0], 8'hA5});
         array_busy = 1'b1;
         grant(13'h0000);
         array_busy = 1'b0;
         @(negedge clk) array_write_done = 1'b1;
         @(negedge clk) array_write_done = 1'b0;
         m_lat = 0;
         grant(13'h0000);
         $display("test guard level %0d done", k);
      end
      cmd(eeprom_prot_pkg::LATCH_SET_CMD, 8);
      m_lat = 1;
      status_write(8'h80);
      @(negedge clk) protect_pin_n = 1'b0;
      cmd(eeprom_prot_pkg::LATCH_SET_CMD, 8);
      m_lat = 1;
      status_read();
      status_write(8'h0C);
      grant(13'h1FFF);
      cmd(eeprom_prot_pkg::LATCH_CLEAR_CMD, 8);
      m_lat = 0;
      status_read();
      @(negedge clk) protect_pin_n = 1'b1;
      cmd(eeprom_prot_pkg::LATCH_SET_CMD, 8);
      m_lat = 1;
      status_write(8'h0C);
      $display("test hardware protection done");
      summarize();
   end
endmodule // testbench
`default_nettype wire
